// ---- hw/rwc_top.sv ----
/*
  Reset source gathering, reset pin sequencing, processor initial state and watchdog,
  with an AHB-Lite register slave.
  Assumes one bus clock hclk, the single slave on the bus, and that asynchronous
  sources and the 1 kHz tick arrive unsynchronised. Vector memory returns data one
  cycle after vec_rd.
*/
`timescale 1ns/10ps

module rwc_top #(
  parameter int PIN_DRIVE_CYC = rwc_pkg::RWC_PIN_DRIVE_CYC,
  parameter int PIN_WAIT_CYC = rwc_pkg::RWC_PIN_WAIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [rwc_pkg::RWC_HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [rwc_pkg::RWC_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [rwc_pkg::RWC_DATA_W-1:0] hrdata,
  input wire logic src_por,
  input wire logic src_lvd,
  input wire logic src_illop,
  input wire logic src_dbg_force,
  input wire logic src_loss_lock,
  input wire logic src_loss_clock,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic bdm_active,
  input wire logic stop_mode,
  input wire logic tick_1khz,
  output logic sys_reset,
  output logic clkgen_self_clock,
  output logic [15:0] vec_addr,
  output logic vec_rd,
  input wire logic [7:0] vec_data,
  output logic [15:0] pc_value,
  output logic pc_load,
  output logic [15:0] sp_value,
  output logic irq_mask_set,
  output logic periph_disable,
  output logic io_force_input,
  output logic io_pullup_off
);
  import rwc_pkg::*;

  // Sequence counters are six bits wide
  if (PIN_DRIVE_CYC < 1 || PIN_DRIVE_CYC > 63 || PIN_WAIT_CYC < 1 || PIN_WAIT_CYC > 63) begin : g_chk
    $error("rwc_top: pin timing must be 1..63 cycles");
  end

  localparam logic [RWC_SEQ_W-1:0] DRIVE_LAST = RWC_SEQ_W'(PIN_DRIVE_CYC - 1);
  localparam logic [RWC_SEQ_W-1:0] WAIT_LAST = RWC_SEQ_W'(PIN_WAIT_CYC - 1);

  logic [RWC_NSYNC-1:0] sync1_ff;
  logic [RWC_NSYNC-1:0] sync2_ff;
  logic [RWC_NSYNC-1:0] raw_in;
  logic tick_prev_ff;
  logic stop_prev_ff;
  rwc_state_type state_ff;
  rwc_state_type nxt_state;
  logic [RWC_SEQ_W-1:0] seq_ff;
  logic [RWC_CAUSE_W-1:0] cause_ff;
  logic [RWC_CAUSE_W-1:0] src_vec;
  logic enter_reset;
  logic wd_en_ff;
  logic wd_tout_ff;
  logic wd_clksel_ff;
  logic opts_lock_ff;
  logic opts2_lock_ff;
  logic [RWC_WDOG_W-1:0] wd_cnt_ff;
  logic [RWC_WDOG_W-1:0] wd_tc;
  logic wd_step;
  logic wd_overflow;
  logic wd_clear;
  logic [7:0] vec_hi_ff;
  logic [15:0] pc_ff;
  logic pc_load_ff;
  logic dph_ff;
  logic dph_write_ff;
  logic [RWC_OFF_W-1:0] dph_off_ff;
  logic dph_hit_ff;
  logic [RWC_DATA_W-1:0] rdata_ff;
  logic [RWC_DATA_W-1:0] nxt_rdata;
  logic addr_take;
  logic addr_hit;
  logic wr_cause;
  logic wr_opts;
  logic wr_opts2;
  logic in_reset;

  // Every asynchronous input passes two flops before any logic reads it
  assign raw_in[RWC_SY_POR] = src_por;
  assign raw_in[RWC_SY_LVD] = src_lvd;
  assign raw_in[RWC_SY_ILLOP] = src_illop;
  assign raw_in[RWC_SY_DBG] = src_dbg_force;
  assign raw_in[RWC_SY_LOCK] = src_loss_lock;
  assign raw_in[RWC_SY_CLK] = src_loss_clock;
  assign raw_in[RWC_SY_PIN] = rst_pin_in;
  assign raw_in[RWC_SY_BDM] = bdm_active;
  assign raw_in[RWC_SY_STOP] = stop_mode;
  assign raw_in[RWC_SY_TICK] = tick_1khz;

  // Per-lane two-flop synchroniser; pin lane idles high like its pull-up
  for (genvar i = 0; i < RWC_NSYNC; i++) begin : g_sync
    localparam logic RST_V = (i == RWC_SY_PIN) ? 1'b1 : 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync1_ff[i] <= RST_V;
        sync2_ff[i] <= RST_V;
      end else begin
        sync1_ff[i] <= raw_in[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  // Edge history for the tick and stop entry, taken from the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_prev_ff <= 1'b0;
      stop_prev_ff <= 1'b0;
    end else begin
      tick_prev_ff <= sync2_ff[RWC_SY_TICK];
      stop_prev_ff <= sync2_ff[RWC_SY_STOP];
    end
  end

  // Source vector in cause-register layout; the pin is known only at the sample
  always_comb begin
    src_vec = RWC_CAUSE_NONE;
    src_vec[RWC_CB_POR] = sync2_ff[RWC_SY_POR];
    src_vec[RWC_CB_LVD] = sync2_ff[RWC_SY_LVD];
    src_vec[RWC_CB_ILLOP] = sync2_ff[RWC_SY_ILLOP];
    src_vec[RWC_CB_LOSS_LOCK] = sync2_ff[RWC_SY_LOCK];
    src_vec[RWC_CB_LOSS_CLK] = sync2_ff[RWC_SY_CLK];
    src_vec[RWC_CB_WDOG] = wd_overflow;
  end

  // The pin counts as a source only outside the sequence, since we drive it then
  assign enter_reset = (|src_vec) || sync2_ff[RWC_SY_DBG] ||
                       (state_ff == RWC_ST_RUN && !sync2_ff[RWC_SY_PIN]);
  assign in_reset = (state_ff != RWC_ST_RUN);

  // Reset sequencer: drive pin, wait, sample, fetch vector
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RWC_ST_RUN: nxt_state = RWC_ST_RUN;
      RWC_ST_DRIVE: if (seq_ff == DRIVE_LAST) nxt_state = RWC_ST_WAIT;
      RWC_ST_WAIT: if (seq_ff == WAIT_LAST) nxt_state = RWC_ST_VEC_HI;
      RWC_ST_VEC_HI: nxt_state = RWC_ST_VEC_LO;
      RWC_ST_VEC_LO: nxt_state = RWC_ST_RUN;
    endcase
    if (enter_reset) begin
      nxt_state = RWC_ST_DRIVE;
    end
  end

  // State and phase counter; a new source restarts the whole sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= RWC_ST_DRIVE;
      seq_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff || enter_reset) begin
        seq_ff <= '0;
      end else begin
        seq_ff <= seq_ff + 1'b1;
      end
    end
  end

  // Cause register holds only the most recent reset's sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_ff <= RWC_CAUSE_POR_VAL;
    end else if (enter_reset) begin
      cause_ff <= src_vec;
    end else if (state_ff == RWC_ST_WAIT && seq_ff == WAIT_LAST && !sync2_ff[RWC_SY_PIN]) begin
      cause_ff[RWC_CB_PIN] <= 1'b1;
    end
  end

  // Vector fetch: high byte arrives in VEC_LO, low byte in the first RUN cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_hi_ff <= 8'h00;
      pc_ff <= 16'h0000;
      pc_load_ff <= 1'b0;
    end else begin
      pc_load_ff <= 1'b0;
      if (state_ff == RWC_ST_VEC_LO) begin
        vec_hi_ff <= vec_data;
      end
      if (state_ff == RWC_ST_VEC_LO && nxt_state == RWC_ST_RUN) begin
        pc_load_ff <= 1'b1;
      end
      if (pc_load_ff) begin
        pc_ff <= {vec_hi_ff, vec_data};
      end
    end
  end

  // Reset pin is open-drain: low while driving, released otherwise
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = (state_ff == RWC_ST_DRIVE);

  // System-wide reset effects last for the whole sequence
  assign sys_reset = in_reset;
  assign clkgen_self_clock = in_reset;
  assign sp_value = RWC_SP_INIT;
  assign irq_mask_set = in_reset;
  assign periph_disable = in_reset;
  assign io_force_input = in_reset;
  assign io_pullup_off = in_reset;
  assign vec_rd = (state_ff == RWC_ST_VEC_HI) || (state_ff == RWC_ST_VEC_LO);
  assign vec_addr = (state_ff == RWC_ST_VEC_LO) ? RWC_VEC_LO_ADDR : RWC_VEC_HI_ADDR;
  assign pc_value = pc_ff;
  assign pc_load = pc_load_ff;

  // AHB-Lite address phase: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_take = hsel && htrans[1] && hready;
  assign addr_hit = (haddr[RWC_HADDR_W-1:RWC_OFF_W] == '0) &&
                    (haddr[RWC_OFF_W-1:0] == RWC_OFF_CAUSE ||
                     haddr[RWC_OFF_W-1:0] == RWC_OFF_OPTS ||
                     haddr[RWC_OFF_W-1:0] == RWC_OFF_OPTS2 ||
                     haddr[RWC_OFF_W-1:0] == RWC_OFF_WDCNT);

  // Data-phase bookkeeping for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dph_write_ff <= 1'b0;
      dph_off_ff <= '0;
      dph_hit_ff <= 1'b0;
    end else if (hready) begin
      dph_ff <= addr_take;
      dph_write_ff <= addr_take && hwrite;
      dph_off_ff <= haddr[RWC_OFF_W-1:0];
      dph_hit_ff <= addr_hit;
    end
  end

  assign wr_cause = dph_write_ff && dph_hit_ff && dph_off_ff == RWC_OFF_CAUSE;
  assign wr_opts = dph_write_ff && dph_hit_ff && dph_off_ff == RWC_OFF_OPTS;
  assign wr_opts2 = dph_write_ff && dph_hit_ff && dph_off_ff == RWC_OFF_OPTS2;

  // Read data is sampled in the address phase so hrdata comes from a flop
  always_comb begin
    nxt_rdata = '0;
    unique case (haddr[RWC_OFF_W-1:0])
      RWC_OFF_CAUSE: nxt_rdata[RWC_CAUSE_W-1:0] = cause_ff;
      RWC_OFF_OPTS: begin
        nxt_rdata[RWC_OB_WD_EN] = wd_en_ff;
        nxt_rdata[RWC_OB_WD_TOUT] = wd_tout_ff;
        nxt_rdata[RWC_OB_LOCKED] = opts_lock_ff;
      end
      RWC_OFF_OPTS2: begin
        nxt_rdata[RWC_OB_WD_CLKSEL] = wd_clksel_ff;
        nxt_rdata[RWC_OB_LOCKED] = opts2_lock_ff;
      end
      RWC_OFF_WDCNT: nxt_rdata[RWC_WDOG_W-1:0] = wd_cnt_ff;
      default: nxt_rdata = '0;
    endcase
    if (!(addr_take && !hwrite && addr_hit)) begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= '0;
    end else if (hready) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign hrdata = rdata_ff;

  // Option registers: defaults restored and unlocked by every reset entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_en_ff <= RWC_WD_EN_RST;
      wd_tout_ff <= RWC_WD_TOUT_RST;
      opts_lock_ff <= 1'b0;
    end else if (in_reset) begin
      wd_en_ff <= RWC_WD_EN_RST;
      wd_tout_ff <= RWC_WD_TOUT_RST;
      opts_lock_ff <= 1'b0;
    end else if (wr_opts && !opts_lock_ff) begin
      wd_en_ff <= hwdata[RWC_OB_WD_EN];
      wd_tout_ff <= hwdata[RWC_OB_WD_TOUT];
      opts_lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_clksel_ff <= RWC_WD_CLKSEL_RST;
      opts2_lock_ff <= 1'b0;
    end else if (in_reset) begin
      wd_clksel_ff <= RWC_WD_CLKSEL_RST;
      opts2_lock_ff <= 1'b0;
    end else if (wr_opts2 && !opts2_lock_ff) begin
      wd_clksel_ff <= hwdata[RWC_OB_WD_CLKSEL];
      opts2_lock_ff <= 1'b1;
    end
  end

  // Terminal count from clock and timeout selection
  always_comb begin
    unique case ({wd_clksel_ff, wd_tout_ff})
      2'b00: wd_tc = RWC_TC_SLOW_SHORT;
      2'b01: wd_tc = RWC_TC_SLOW_LONG;
      2'b10: wd_tc = RWC_TC_BUS_SHORT;
      2'b11: wd_tc = RWC_TC_BUS_LONG;
    endcase
  end

  // Count steps; debug and stop both halt it, and stop entry also clears it on the slow clock
  assign wd_step = wd_en_ff && !in_reset && !sync2_ff[RWC_SY_BDM] &&
                   !sync2_ff[RWC_SY_STOP] &&
                   (wd_clksel_ff || (sync2_ff[RWC_SY_TICK] && !tick_prev_ff));
  assign wd_overflow = wd_step && (wd_cnt_ff >= wd_tc);

  // Clear requests beat a step in the same cycle, but not the overflowing step, whose overflow still resets
  assign wd_clear = in_reset ||
                    wr_cause ||
                    (wr_opts && !opts_lock_ff) || (wr_opts2 && !opts2_lock_ff) ||
                    (!wd_clksel_ff && sync2_ff[RWC_SY_STOP] && !stop_prev_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_ff <= '0;
    end else if (wd_clear || wd_overflow) begin
      wd_cnt_ff <= '0;
    end else if (wd_step) begin
      wd_cnt_ff <= wd_cnt_ff + 1'b1;
    end
  end

endmodule : rwc_top

// ---- hw/rwc_pkg.sv ----
/*
  Constants, register map and state encoding for the reset and watchdog control block.
  Assumes a 32-bit AHB-Lite register bus and a bus clock of 25 MHz.
*/
package rwc_pkg;

  // Bus geometry
  localparam int RWC_HADDR_W = 32;
  localparam int RWC_DATA_W = 32;
  localparam int RWC_OFF_W = 8;

  // Register byte offsets
  localparam logic [7:0] RWC_OFF_CAUSE = 8'h00;
  localparam logic [7:0] RWC_OFF_OPTS = 8'h04;
  localparam logic [7:0] RWC_OFF_OPTS2 = 8'h08;
  localparam logic [7:0] RWC_OFF_WDCNT = 8'h0c;

  // Reset cause bit positions in reset_cause_reg
  localparam int RWC_CB_LVD = 1;
  localparam int RWC_CB_LOSS_CLK = 2;
  localparam int RWC_CB_LOSS_LOCK = 3;
  localparam int RWC_CB_ILLOP = 4;
  localparam int RWC_CB_WDOG = 5;
  localparam int RWC_CB_PIN = 6;
  localparam int RWC_CB_POR = 7;
  localparam int RWC_CAUSE_W = 8;
  localparam logic [7:0] RWC_CAUSE_POR_VAL = 8'h80;
  localparam logic [7:0] RWC_CAUSE_NONE = 8'h00;

  // Option bit positions
  localparam int RWC_OB_WD_EN = 7;
  localparam int RWC_OB_WD_TOUT = 6;
  localparam int RWC_OB_WD_CLKSEL = 7;
  localparam int RWC_OB_LOCKED = 0;

  // Defaults after any reset: enabled, bus clock, long timeout
  localparam logic RWC_WD_EN_RST = 1'b1;
  localparam logic RWC_WD_CLKSEL_RST = 1'b1;
  localparam logic RWC_WD_TOUT_RST = 1'b1;

  // Watchdog terminal counts (overflow count minus one)
  localparam int RWC_WDOG_W = 18;
  localparam logic [17:0] RWC_TC_SLOW_SHORT = 18'h0_001f;
  localparam logic [17:0] RWC_TC_SLOW_LONG = 18'h0_00ff;
  localparam logic [17:0] RWC_TC_BUS_SHORT = 18'h0_1fff;
  localparam logic [17:0] RWC_TC_BUS_LONG = 18'h3_ffff;

  // Reset pin timing, in bus cycles
  localparam int RWC_PIN_DRIVE_CYC = 34;
  localparam int RWC_PIN_WAIT_CYC = 38;
  localparam int RWC_SEQ_W = 6;

  // Processor initial state
  localparam logic [15:0] RWC_VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] RWC_VEC_LO_ADDR = 16'hffff;
  localparam logic [15:0] RWC_SP_INIT = 16'h00ff;

  // Synchroniser lanes
  localparam int RWC_NSYNC = 10;
  localparam int RWC_SY_POR = 0;
  localparam int RWC_SY_LVD = 1;
  localparam int RWC_SY_ILLOP = 2;
  localparam int RWC_SY_DBG = 3;
  localparam int RWC_SY_LOCK = 4;
  localparam int RWC_SY_CLK = 5;
  localparam int RWC_SY_PIN = 6;
  localparam int RWC_SY_BDM = 7;
  localparam int RWC_SY_STOP = 8;
  localparam int RWC_SY_TICK = 9;

  // Reset sequencer states
  typedef enum logic [4:0] {
    RWC_ST_RUN = 5'b00001,
    RWC_ST_DRIVE = 5'b00010,
    RWC_ST_WAIT = 5'b00100,
    RWC_ST_VEC_HI = 5'b01000,
    RWC_ST_VEC_LO = 5'b10000
  } rwc_state_type;

endpackage : rwc_pkg

// ---- tb/rwc_top_props.sv ----
/*
  Checker for the reset sequence, pin drive, vector fetch and start state.
  Assumes it is bound to rwc_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module rwc_top_props #(
  parameter int PIN_DRIVE_CYC = 34,
  parameter int PIN_WAIT_CYC = 38
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic src_por,
  input wire logic src_lvd,
  input wire logic src_illop,
  input wire logic src_dbg_force,
  input wire logic src_loss_lock,
  input wire logic src_loss_clock,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic sys_reset,
  input wire logic clkgen_self_clock,
  input wire logic [15:0] vec_addr,
  input wire logic vec_rd,
  input wire logic [7:0] vec_data,
  input wire logic [15:0] pc_value,
  input wire logic pc_load,
  input wire logic [15:0] sp_value,
  input wire logic irq_mask_set,
  input wire logic periph_disable,
  input wire logic io_force_input,
  input wire logic io_pullup_off
);
  logic [7:0] drv_cnt_ff;
  logic any_src;

  // Length of the current pin-drive stretch; restarts whenever the pin is let go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv_cnt_ff <= 8'h00;
    end else if (rst_pin_oe) begin
      drv_cnt_ff <= drv_cnt_ff + 8'h01;
    end else begin
      drv_cnt_ff <= 8'h00;
    end
  end

  // Any internal reset source
  assign any_src = src_por | src_lvd | src_illop | src_dbg_force | src_loss_lock | src_loss_clock;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Vector fetch, high byte first, then the first run cycle
  sequence fetch_s;
    vec_rd && vec_addr == 16'hfffe ##1 vec_rd && vec_addr == 16'hffff ##1 pc_load && !sys_reset;
  endsequence

  pin_drive_len_a: assert property ($fell(rst_pin_oe) |-> drv_cnt_ff == 8'(PIN_DRIVE_CYC))
    else $error("pin drive stretch has wrong length");
  fetch_order_a: assert property ($fell(rst_pin_oe) |-> ##PIN_WAIT_CYC fetch_s)
    else $error("vector fetch not at end of wait");
  pc_vector_a: assert property (pc_load |=> pc_value == {$past(vec_data, 2), $past(vec_data)})
    else $error("pc not built from vector bytes");
  pc_pulse_a: assert property (pc_load |-> $fell(sys_reset) ##1 !pc_load)
    else $error("pc load not a single pulse at run start");
  start_state_a: assert property (sp_value == 16'h00ff &&
    {irq_mask_set, periph_disable, io_force_input, io_pullup_off, clkgen_self_clock} == {5{sys_reset}})
    else $error("start state outputs do not follow reset");
  pin_low_drv_a: assert property (rst_pin_oe |-> !rst_pin_out && sys_reset)
    else $error("pin driven outside reset or high");
  entry_drive_a: assert property ($rose(sys_reset) |-> rst_pin_oe && !pc_load)
    else $error("reset entry without pin drive");
  src_entry_a: assert property (!sys_reset && any_src |-> ##[1:4] rst_pin_oe)
    else $error("source did not start reset");
  pin_entry_a: assert property (!sys_reset && !rst_pin_in |-> ##[1:4] rst_pin_oe)
    else $error("low pin did not start reset");
endmodule : rwc_top_props

// ---- tb/rwc_pin_model.sv ----
/*
  Far side of the block: reset pin wiring with pull-up and a holder, plus vector memory.
  Assumes the memory answers one cycle after each fetch, as the block expects.
*/
`timescale 1ns/10ps
module rwc_pin_model #(
  parameter logic [7:0] VEC_HI = 8'ha5,
  parameter logic [7:0] VEC_LO = 8'hc3
) (
  input wire logic hclk,
  input wire logic rst_pin_oe,
  input wire logic rst_pin_out,
  input wire logic ext_low,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  output logic rst_pin_in,
  output logic [7:0] vec_data
);
  logic [7:0] mem_q = 8'h3c;

  // Pin level: any party pulling low wins, otherwise the pull-up
  assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || ext_low);
  assign vec_data = mem_q;

  // Idle memory bus toggles so a stale byte is never mistaken for an answer
  always_ff @(posedge hclk) begin
    if (vec_rd) begin
      mem_q <= (vec_addr == 16'hfffe) ? VEC_HI : VEC_LO;
    end else begin
      mem_q <= ~mem_q;
    end
  end
endmodule : rwc_pin_model

// ---- tb/rwc_top_tb.sv ----
/*
  Self-checking bench for the reset and watchdog block.
  Assumes one 25 MHz clock and shortened pin timing through the block's parameters.
*/
`timescale 1ns/10ps
module rwc_top_tb;
  import rwc_pkg::*;
  localparam int DRV = 5;
  localparam int WT = 7;
  localparam int SR = 0;
  localparam int PL = 1;
  localparam int RDY = 2;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] src = 6'h00;
  logic bdm_active = 1'b0;
  logic stop_mode = 1'b0;
  logic tick_1khz = 1'b0;
  logic ext_low = 1'b0;
  logic hready, hreadyout, hresp, rst_pin_in, rst_pin_out, rst_pin_oe, vec_rd, pc_load;
  logic sys_reset, clkgen_self_clock, irq_mask_set, periph_disable, io_force_input;
  logic io_pullup_off;
  logic [31:0] hrdata, rd;
  logic [15:0] vec_addr, pc_value, sp_value;
  logic [7:0] vec_data;
  wire logic src_por = src[0];
  wire logic src_lvd = src[1];
  wire logic src_illop = src[2];
  wire logic src_dbg_force = src[3];
  wire logic src_loss_lock = src[4];
  wire logic src_loss_clock = src[5];
  int n_fail = 0;
  int check_count = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #20 hclk = ~hclk;

  rwc_top #(.PIN_DRIVE_CYC(DRV), .PIN_WAIT_CYC(WT)) dut (.*);
  rwc_pin_model u_pin (.*);

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk

  // Bounded wait for one of four status signals; running out ends the run
  task automatic wait_sig(input int k, input int lim, output int n);
    logic [3:0] v;
    for (n = 0; n < lim; n++) begin
      @(posedge hclk);
      v = {vec_rd, hready, pc_load, sys_reset};
      if (v[k] === 1'b1) return;
    end
    $display("[FAIL] %0t wait limit reached", $time);
    n_fail++;
    final_report();
  endtask : wait_sig

  // One single-word transfer; read data is taken at the closing edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    wait_sig(RDY, 50, n);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_sig(RDY, 50, n);
    rd = hrdata;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic ticks(input int k);
    repeat (k) begin
      tick_1khz <= 1'b1;
      repeat (3) @(posedge hclk);
      tick_1khz <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask : ticks

  task automatic s_boot;
    int n;
    chk(32'({irq_mask_set, periph_disable, io_force_input, io_pullup_off}), 32'hf);
    wait_sig(PL, 300, n);
    rdc(RWC_OFF_CAUSE, 32'h80);
    rdc(RWC_OFF_OPTS, 32'hc0);
    rdc(RWC_OFF_OPTS2, 32'h80);
    rdc(8'h40, 32'h0);
    chk(32'(pc_value), 32'h0000_a5c3);
    chk(32'({irq_mask_set, periph_disable, clkgen_self_clock}), 32'h0);
    $display("boot done");
  endtask : s_boot

  task automatic s_wdog_bus;
    int n;
    bus(1'b1, RWC_OFF_OPTS, 32'h80);
    rdc(RWC_OFF_OPTS, 32'h81);
    bus(1'b1, RWC_OFF_OPTS, 32'h40);
    rdc(RWC_OFF_OPTS, 32'h81);
    bus(1'b1, RWC_OFF_OPTS2, 32'h80);
    bus(1'b0, RWC_OFF_WDCNT, 32'h0);
    chk(32'(rd < 3), 32'h1);
    rdc(RWC_OFF_OPTS2, 32'h81);
    repeat (200) @(posedge hclk);
    bus(1'b1, RWC_OFF_CAUSE, 32'hff);
    rdc(RWC_OFF_CAUSE, 32'h80);
    wait_sig(SR, 9000, n);
    chk(32'(n > 8186 && n < 8194), 32'h1);
    wait_sig(PL, 300, n);
    rdc(RWC_OFF_CAUSE, 32'h20);
    rdc(RWC_OFF_OPTS, 32'hc0);
    // Counting restarts at zero in the first run cycle, five steps before this sample
    bus(1'b0, RWC_OFF_WDCNT, 32'h0);
    chk(rd, 32'h5);
    $display("bus clock watchdog done");
  endtask : s_wdog_bus

  task automatic s_hold;
    logic [31:0] a;
    repeat (20) @(posedge hclk);
    stop_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b0, RWC_OFF_WDCNT, 32'h0);
    a = rd;
    repeat (30) @(posedge hclk);
    rdc(RWC_OFF_WDCNT, a);
    stop_mode <= 1'b0;
    bdm_active <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b0, RWC_OFF_WDCNT, 32'h0);
    a = rd;
    repeat (30) @(posedge hclk);
    rdc(RWC_OFF_WDCNT, a);
    bdm_active <= 1'b0;
    repeat (10) @(posedge hclk);
    bus(1'b0, RWC_OFF_WDCNT, 32'h0);
    chk(32'(rd > a && rd < a + 32'h14), 32'h1);
    $display("stop and debug hold done");
  endtask : s_hold

  task automatic s_slow;
    int n;
    bus(1'b1, RWC_OFF_OPTS, 32'h80);
    bus(1'b1, RWC_OFF_OPTS2, 32'h00);
    ticks(10);
    rdc(RWC_OFF_WDCNT, 32'ha);
    bdm_active <= 1'b1;
    repeat (4) @(posedge hclk);
    ticks(5);
    rdc(RWC_OFF_WDCNT, 32'ha);
    bdm_active <= 1'b0;
    stop_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc(RWC_OFF_WDCNT, 32'h0);
    stop_mode <= 1'b0;
    repeat (4) @(posedge hclk);
    ticks(31);
    rdc(RWC_OFF_WDCNT, 32'h1f);
    chk(32'(sys_reset), 32'h0);
    ticks(1);
    wait_sig(SR, 20, n);
    wait_sig(PL, 300, n);
    rdc(RWC_OFF_CAUSE, 32'h20);
    $display("slow clock watchdog done");
  endtask : s_slow

  task automatic s_off;
    bus(1'b1, RWC_OFF_OPTS, 32'h00);
    bus(1'b1, RWC_OFF_OPTS2, 32'h00);
    ticks(40);
    rdc(RWC_OFF_WDCNT, 32'h0);
    chk(32'(sys_reset), 32'h0);
    $display("watchdog off done");
  endtask : s_off

  task automatic s_sources;
    logic [7:0] cz [6] = '{8'h80, 8'h02, 8'h10, 8'h00, 8'h08, 8'h04};
    int n;
    for (int i = 0; i < 6; i++) begin
      src <= 6'(1 << i);
      @(posedge hclk);
      src <= 6'h00;
      wait_sig(PL, 300, n);
      rdc(RWC_OFF_CAUSE, 32'(cz[i]));
    end
    $display("reset sources done");
  endtask : s_sources

  task automatic s_pin;
    int n;
    ext_low <= 1'b1;
    @(posedge hclk);
    ext_low <= 1'b0;
    wait_sig(PL, 300, n);
    rdc(RWC_OFF_CAUSE, 32'h0);
    // Hold the pin past the sample, but let go before the synchronised level reaches run
    ext_low <= 1'b1;
    repeat (DRV + WT + 2) @(posedge hclk);
    ext_low <= 1'b0;
    wait_sig(PL, 300, n);
    rdc(RWC_OFF_CAUSE, 32'h40);
    repeat (2 * (DRV + WT) + 30) @(posedge hclk);
    $display("reset pin done");
  endtask : s_pin

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_boot();
    s_wdog_bus();
    s_hold();
    s_slow();
    s_off();
    s_sources();
    s_pin();
    final_report();
  end
endmodule : rwc_top_tb

bind rwc_top rwc_top_props #(
  .PIN_DRIVE_CYC(PIN_DRIVE_CYC),
  .PIN_WAIT_CYC(PIN_WAIT_CYC)
) u_props (.*);
